// *** efdc_ctrl.sv ***
// enclave flag, protection key and debug control with axi4-lite registers
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`include "efdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module efdc_ctrl
    import efdc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // axi4-lite write
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // axi4-lite read
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // instruction events
    input  wire logic [3:0]  cmdCode,
    input  wire logic        cmdValid,
    input  wire logic        cmdFault,
    input  wire logic        cmdIret,
    input  wire logic [31:0] cmdFlags,
    // results
    output logic [31:0]      flagsOut,
    output logic             stepPending,
    output logic             mtfPending,
    output logic             gpFault
);
    // register state
    logic [31:0] ctrl_ff;
    logic [31:0] flags_ff;
    logic [31:0] keyReg_ff;
    logic [31:0] savFlg_ff;
    logic [31:0] savKey_ff;
    logic [5:0]  access_ff;
    efdc_state_t state_ff;
    logic        optIn_ff;
    logic        entryTf_ff;
    logic        masked_ff;
    logic        step_ff;
    logic        mtf_ff;
    logic        gpf_ff;
    logic        dbgRef_ff;
    logic        trampStep_ff;
    logic        awHave_ff;
    logic        wHave_ff;
    logic [7:0]  awAddr_ff;
    logic [31:0] wData_ff;
    logic [3:0]  wStrb_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    // field decode
    wire        pvi      = ctrl_ff[`EFDC_C_PVI];
    wire        pke      = ctrl_ff[`EFDC_C_PKE];
    wire        vmxNr    = ctrl_ff[`EFDC_C_VMXNR];
    wire        mtfEn    = ctrl_ff[`EFDC_C_MTFEN] & vmxNr;
    wire        xfrmPk   = ctrl_ff[`EFDC_C_XFRMPK] & `EFDC_PROTECTION_KEY_REG_CAP;
    wire        dbgAttr  = ctrl_ff[`EFDC_C_DEBUGATTR];
    wire [1:0]  current_privilege_level      = ctrl_ff[`EFDC_C_CPL_LO +: 2];
    wire [1:0]  io_privilege_level     = ctrl_ff[`EFDC_C_IO_PRIVILEGE_LEVEL_LO +: 2];
    wire        inEnc    = (state_ff == EFDC_INSIDE);
    wire        effCpl3  = inEnc | (current_privilege_level == 2'h3);
    wire        cmdOk    = cmdValid;
    wire efdc_cmd_t cmd  = efdc_cmd_t'(cmdCode);
    wire        isEnter  = cmdOk & (cmd == EFDC_ENTER) & ~inEnc;
    wire        isResume = cmdOk & (cmd == EFDC_RESUME) & ~inEnc;
    wire        isEntry  = isEnter | isResume;
    wire        isExit   = cmdOk & (cmd == EFDC_EXIT) & inEnc;
    wire        isAex    = cmdOk & (cmd == EFDC_AEX) & inEnc;
    wire        isSti    = cmdOk & (cmd == EFDC_STI);
    wire        isPopf   = cmdOk & (cmd == EFDC_POP_FLAGS_INSTR);
    wire        isPriv   = cmdOk & (cmd == EFDC_PRIVINS);
    wire        isRptKey = cmdOk & (cmd == EFDC_RPTKEY);
    wire        isAdd    = cmdOk & (cmd == EFDC_PAGEADD);
    wire        isDbgRd  = cmdOk & (cmd == EFDC_DBGRD);
    wire        isDbgWr  = cmdOk & (cmd == EFDC_DBGWR);
    wire        isOthVm  = cmdOk & (cmd == EFDC_OTHERVMX);
    wire        isBound  = cmdOk & (cmd == EFDC_BOUNDARY);
    wire        tfNow    = flags_ff[`EFDC_F_TF];
    wire        stiGp    = pvi & effCpl3 & ~flags_ff[`EFDC_F_VM] & (io_privilege_level != 2'h3)
                         & flags_ff[`EFDC_F_VIP] & ~flags_ff[`EFDC_F_VIF];
    wire        dbgAllow = dbgAttr;

    // single-step and monitor-trap event sources
    // a faulting EFDC_PRIVINS or EFDC_RPTKEY hands over to its handler, so no step trap
    wire stepSet = (isPriv & tfNow & ~cmdFault)
                 | (isRptKey & tfNow & ~masked_ff & ~cmdFault)
                 | (isExit & ~optIn_ff & entryTf_ff)
                 | (trampStep_ff & cmdIret);
    // monitor trap still pends, after the fault delivery
    wire mtfSet  = (isPriv & mtfEn)
                 | (isRptKey & mtfEn & ~masked_ff)
                 | (isExit & ~optIn_ff & entryTf_ff & mtfEn)
                 | (isAex & ~optIn_ff & mtfEn);

    // flags next value
    logic [31:0] nxt_flags;
    always_comb begin
        nxt_flags = flags_ff;
        if (isEnter) begin
            nxt_flags = flags_ff;
        end else if (isResume) begin
            nxt_flags = cmdFlags;
            nxt_flags[`EFDC_F_VIP] = flags_ff[`EFDC_F_VIP];
            nxt_flags[`EFDC_F_VIF] = flags_ff[`EFDC_F_VIF];
        end
        if (isEntry & ~ctrl_ff[`EFDC_C_OPTIN]) begin
            nxt_flags[`EFDC_F_TF] = 1'b0;
        end
        if ((isExit | isAex) & ~optIn_ff) begin
            nxt_flags[`EFDC_F_TF] = entryTf_ff;
        end
        if (isSti & ~stiGp) begin
            nxt_flags[`EFDC_F_IF] = 1'b1;
        end
        if (isPopf) begin
            nxt_flags = cmdFlags;
            if (inEnc & ~optIn_ff) begin
                nxt_flags[`EFDC_F_TF] = 1'b0;
            end
        end
    end

    // bus handshake decode
    wire        wrGo   = awHave_ff & wHave_ff & ~bvalid_ff;
    wire        rdGo   = arvalid & ~rvalid_ff;
    wire        wrCtrl = wrGo & (awAddr_ff == `EFDC_ADDR_CTRL);
    wire        wrKey  = wrGo & (awAddr_ff == `EFDC_ADDR_KEYREG);
    wire        wrAcc  = wrGo & (awAddr_ff == `EFDC_ADDR_ACCESS);
    wire        wrOk   = wrCtrl | wrKey | wrAcc;
    wire        keyOk  = pke;
    wire        optInW = ctrl_ff[`EFDC_C_OPTIN];
    wire efdc_acc_t acc = efdc_acc_t'(access_ff);
    wire        domainApplies = pke & ~acc.implicitAcc
                              & (~acc.enclaveAcc | acc.userPage);
    wire        accDeny = (domainApplies & ~acc.domainOk) | ~acc.legacyOk
                        | (acc.enclaveAcc & ~acc.enclaveOk);
    wire [31:0] status = {23'h0, masked_ff, accDeny, `EFDC_PROTECTION_KEY_REG_CAP, dbgRef_ff,
                          gpf_ff, mtf_ff, step_ff, optIn_ff, inEnc};
    logic [31:0] rdMux;
    logic        rdHit;
    always_comb begin
        rdHit = 1'b1;
        case (araddr)
            `EFDC_ADDR_CTRL:   rdMux = ctrl_ff;
            `EFDC_ADDR_FLAGS:  rdMux = flags_ff;
            `EFDC_ADDR_STATUS: rdMux = status;
            `EFDC_ADDR_KEYREG: rdMux = keyOk ? keyReg_ff : 32'h0;
            `EFDC_ADDR_SAVFLG: rdMux = savFlg_ff;
            `EFDC_ADDR_SAVKEY: rdMux = savKey_ff;
            `EFDC_ADDR_ACCESS: rdMux = {26'h0, access_ff};
            default: begin
                rdMux = 32'h0;
                rdHit = 1'b0;
            end
        endcase
    end
    logic [31:0] wMerged;
    always_comb begin
        wMerged = (awAddr_ff == `EFDC_ADDR_KEYREG) ? keyReg_ff : ctrl_ff;
        for (int i = 0; i < 4; i++) begin
            if (wStrb_ff[i]) wMerged[8*i +: 8] = wData_ff[8*i +: 8];
        end
    end

    // bus channel registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            awHave_ff <= 1'b0;
            wHave_ff  <= 1'b0;
            awAddr_ff <= 8'h00;
            wData_ff  <= 32'h0;
            wStrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= 2'h0;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0;
            rresp_ff  <= 2'h0;
        end else begin
            if (awvalid & ~awHave_ff) begin
                awHave_ff <= 1'b1;
                awAddr_ff <= awaddr;
            end
            if (wvalid & ~wHave_ff) begin
                wHave_ff <= 1'b1;
                wData_ff <= wdata;
                wStrb_ff <= wstrb;
            end
            if (wrGo) begin
                awHave_ff <= 1'b0;
                wHave_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wrOk ? `EFDC_RESP_OKAY : `EFDC_RESP_SLVERR;
            end else if (bvalid_ff & bready) begin
                bvalid_ff <= 1'b0;
            end
            if (rdGo) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= rdMux;
                rresp_ff  <= rdHit ? `EFDC_RESP_OKAY : `EFDC_RESP_SLVERR;
            end else if (rvalid_ff & rready) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // core state
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_ff      <= 32'h0;
            flags_ff     <= 32'h2;
            keyReg_ff    <= 32'h0;
            savFlg_ff    <= 32'h0;
            savKey_ff    <= 32'h0;
            access_ff    <= 6'h0;
            state_ff     <= EFDC_OUTSIDE;
            optIn_ff     <= 1'b0;
            entryTf_ff   <= 1'b0;
            masked_ff    <= 1'b0;
            step_ff      <= 1'b0;
            mtf_ff       <= 1'b0;
            gpf_ff       <= 1'b0;
            dbgRef_ff    <= 1'b0;
            trampStep_ff <= 1'b0;
        end else begin
            flags_ff <= nxt_flags;
            if (wrCtrl) ctrl_ff <= wMerged;
            if (wrAcc) access_ff <= wData_ff[5:0];
            if (isAdd) ctrl_ff[`EFDC_C_OPTIN] <= 1'b0;
            if (isDbgWr & dbgAllow) ctrl_ff[`EFDC_C_OPTIN] <= wData_ff[0];
            dbgRef_ff <= (isDbgRd | isDbgWr) ? ~dbgAllow : dbgRef_ff;
            if (wrKey & keyOk) keyReg_ff <= wMerged;
            if (isEntry) begin
                state_ff   <= EFDC_INSIDE;
                optIn_ff   <= optInW;
                entryTf_ff <= tfNow;
                masked_ff  <= ~optInW;
            end
            if (isResume & xfrmPk) keyReg_ff <= savKey_ff;
            if (isExit | isAex) begin
                state_ff  <= EFDC_OUTSIDE;
                masked_ff <= 1'b0;
            end
            if (isAex) begin
                savFlg_ff <= flags_ff;
                savFlg_ff[`EFDC_F_TF] <= 1'b0;
                trampStep_ff <= optIn_ff ? tfNow : entryTf_ff;
                if (xfrmPk) begin
                    savKey_ff <= keyReg_ff;
                    keyReg_ff <= 32'h0;
                end
            end else if (cmdIret) begin
                trampStep_ff <= 1'b0;
            end
            if (stepSet) step_ff <= 1'b1;
            else if (isBound) step_ff <= 1'b0;
            if (mtfSet) mtf_ff <= 1'b1;
            else if (isOthVm | isBound) mtf_ff <= 1'b0;
            if (isSti) gpf_ff <= stiGp;
            else if (cmdOk) gpf_ff <= 1'b0;
        end
    end

    // outputs straight from flops
    assign awready     = ~awHave_ff;
    assign wready      = ~wHave_ff;
    assign bvalid      = bvalid_ff;
    assign bresp       = bresp_ff;
    assign arready     = ~rvalid_ff;
    assign rvalid      = rvalid_ff;
    assign rdata       = rdata_ff;
    assign rresp       = rresp_ff;
    assign flagsOut    = flags_ff;
    assign stepPending = step_ff;
    assign mtfPending  = mtf_ff;
    assign gpFault     = gpf_ff;

    // checks
    a_enter_keeps_vflags: assert property (@(posedge mclk) disable iff (rst)
        isEnter |=> flags_ff[20:19] == $past(flags_ff[20:19]))
        else $error("enter changed virtual flags");
    a_resume_keeps_vflags: assert property (@(posedge mclk) disable iff (rst)
        isResume |=> flags_ff[20:19] == $past(flags_ff[20:19]))
        else $error("resume changed virtual flags");
    a_aex_saves_vflags: assert property (@(posedge mclk) disable iff (rst)
        isAex |=> savFlg_ff[20:19] == $past(flags_ff[20:19]) && savFlg_ff[8] == 1'b0)
        else $error("async exit save wrong");
    a_sti_fault_holds: assert property (@(posedge mclk) disable iff (rst)
        isSti && stiGp && !isPopf |=> gpFault && flags_ff[9] == $past(flags_ff[9]))
        else $error("set-interrupt fault wrong");
    a_sti_iopl3_sets: assert property (@(posedge mclk) disable iff (rst)
        isSti && io_privilege_level == 2'h3 && !isPopf |=> flags_ff[9] && !gpFault)
        else $error("set-interrupt at io_privilege_level 3 wrong");
    a_pop_flags_instr_optout_tf: assert property (@(posedge mclk) disable iff (rst)
        isPopf && inEnc && !optIn_ff |=> !flags_ff[8])
        else $error("pop-flags let trap through");
    a_priv_step_pend: assert property (@(posedge mclk) disable iff (rst)
        isPriv && tfNow && !cmdFault |=> stepPending)
        else $error("single-step not pended");
    a_add_clears_optin: assert property (@(posedge mclk) disable iff (rst)
        isAdd && !isDbgWr && !wrCtrl |=> !ctrl_ff[6])
        else $error("page add kept opt-in");
endmodule : efdc_ctrl
`default_nettype wire

// *** efdc_cfg.svh ***
// constants for the enclave flag and debug control block
`ifndef EFDC_CFG_SVH
`define EFDC_CFG_SVH
`define EFDC_ADDR_CTRL      8'h00
`define EFDC_ADDR_FLAGS     8'h04
`define EFDC_ADDR_CMD       8'h08
`define EFDC_ADDR_STATUS    8'h0C
`define EFDC_ADDR_KEYREG    8'h10
`define EFDC_ADDR_SAVFLG    8'h14
`define EFDC_ADDR_SAVKEY    8'h18
`define EFDC_ADDR_ACCESS    8'h1C
// control register bits
`define EFDC_C_PVI          0
`define EFDC_C_PKE          1
`define EFDC_C_VMXNR        2
`define EFDC_C_MTFEN        3
`define EFDC_C_XFRMPK       4
`define EFDC_C_DEBUGATTR    5
`define EFDC_C_OPTIN        6
`define EFDC_C_CPL_LO       7
`define EFDC_C_IO_PRIVILEGE_LEVEL_LO      9
// flags register bits
`define EFDC_F_TF           8
`define EFDC_F_IF           9
`define EFDC_F_VM           17
`define EFDC_F_VIF          19
`define EFDC_F_VIP          20
// status bits
`define EFDC_S_INENC        0
`define EFDC_S_OPTIN        1
`define EFDC_S_SSPEND       2
`define EFDC_S_MTFPEND      3
`define EFDC_S_GPF          4
`define EFDC_S_DBGREF       5
`define EFDC_S_PKCAP        6
`define EFDC_S_ACCDENY      7
`define EFDC_S_MASKED       8
`define EFDC_PROTECTION_KEY_REG_CAP       1'b1
`define EFDC_RESP_OKAY      2'h0
`define EFDC_RESP_SLVERR    2'h2
`endif

// *** efdc_pkg.sv ***
// types for the enclave flag and debug control block
package efdc_pkg;
    typedef enum logic [3:0] {
        EFDC_NOP      = 4'h0,
        EFDC_ENTER    = 4'h1,
        EFDC_RESUME   = 4'h2,
        EFDC_EXIT     = 4'h3,
        EFDC_AEX      = 4'h4,
        EFDC_STI      = 4'h5,
        EFDC_POP_FLAGS_INSTR     = 4'h6,
        EFDC_PRIVINS  = 4'h7,
        EFDC_RPTKEY   = 4'h8,
        EFDC_PAGEADD  = 4'h9,
        EFDC_DBGRD    = 4'hA,
        EFDC_DBGWR    = 4'hB,
        EFDC_OTHERVMX = 4'hC,
        EFDC_BOUNDARY = 4'hD
    } efdc_cmd_t;
    typedef enum logic [1:0] {
        EFDC_OUTSIDE = 2'b00,
        EFDC_INSIDE  = 2'b01
    } efdc_state_t;
    typedef struct packed {
        logic        enclaveAcc;
        logic        userPage;
        logic        implicitAcc;
        logic        domainOk;
        logic        legacyOk;
        logic        enclaveOk;
    } efdc_acc_t;
endpackage : efdc_pkg

// *** tb_top.sv ***
// self-checking bench for the enclave flag and debug control block
`include "efdc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import efdc_pkg::*;
    localparam logic [31:0] CPL3 = 32'h0000_0180;
    localparam logic [31:0] IOPL3 = 32'h0000_0600;
    localparam logic [31:0] TFI = 32'h0000_0102;
    localparam int LIMIT = 20000;
    logic mclk = 1'b0, rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, cmdFlags = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF, cmdCode = 4'h0;
    logic cmdValid = 1'b0, cmdFault = 1'b0, cmdIret = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, stepPending, mtfPending, gpFault;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata, flagsOut, d;
    logic [1:0] vv;
    int mismatches = 0, checkCount = 0, cycles = 0;

    efdc_ctrl dut (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .cmdCode(cmdCode), .cmdValid(cmdValid),
        .cmdFault(cmdFault), .cmdIret(cmdIret), .cmdFlags(cmdFlags), .flagsOut(flagsOut),
        .stepPending(stepPending), .mtfPending(mtfPending), .gpFault(gpFault));

    always #5 mclk = ~mclk;

    // watchdog: a hang ends the run as a mismatch
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checkCount = checkCount + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk

    // address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        logic hAw, hW, hB;
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge mclk);
            hAw = awvalid & awready;
            hW = wvalid & wready;
            hB = bvalid & bready;
            resp = bresp;
            @(posedge mclk);
            if (hAw) awvalid <= 1'b0;
            if (hW) wvalid <= 1'b0;
            if (hB) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        logic hAr, hR;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge mclk);
            hAr = arvalid & arready;
            hR = rvalid & rready;
            v = rdata;
            resp = rresp;
            @(posedge mclk);
            if (hAr) arvalid <= 1'b0;
            if (hR) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask : rd

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                         input string n);
        logic [31:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk(n, v & m, e);
    endtask : rdchk

    task automatic ctl(input logic [31:0] v);
        logic [1:0] rs;
        wr(`EFDC_ADDR_CTRL, v, rs);
    endtask : ctl

    // one-cycle event; its effect is settled two edges later
    task automatic cmd(input efdc_cmd_t c, input logic [31:0] f, input logic flt);
        @(posedge mclk);
        cmdCode <= c;
        cmdFlags <= f;
        cmdFault <= flt;
        cmdValid <= 1'b1;
        @(posedge mclk);
        cmdValid <= 1'b0;
        cmdFault <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : cmd

    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        #1;
        chk("flags after reset", flagsOut, 32'h0000_0002);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0041, 32'h0000_0040, "key cap");
        rd(8'h20, d, r);
        chk("unmapped resp", {30'h0, r}, {30'h0, `EFDC_RESP_SLVERR});
        chk("unmapped data", d, 32'h0);
        wr(`EFDC_ADDR_FLAGS, 32'hFFFF_FFFF, r);
        chk("read-only resp", {30'h0, r}, {30'h0, `EFDC_RESP_SLVERR});
        // io privilege 3: interrupt flag set, virtual flags ignored
        ctl(32'h1 | CPL3 | IOPL3);
        cmd(EFDC_STI, 32'h0, 1'b0);
        chk("sti if", {31'h0, flagsOut[`EFDC_F_IF]}, 32'h1);
        chk("sti vflags", {30'h0, flagsOut[20:19]}, 32'h0);
        chk("sti gp", {31'h0, gpFault}, 32'h0);
        ctl(32'h1 | CPL3);
        cmd(EFDC_POP_FLAGS_INSTR, 32'h0010_0002, 1'b0);
        cmd(EFDC_STI, 32'h0, 1'b0);
        chk("sti vip", {31'h0, flagsOut[`EFDC_F_VIP]}, 32'h1);
        chk("sti fault", {31'h0, gpFault}, 32'h1);
        chk("sti no if", {30'h0, flagsOut[`EFDC_F_IF], flagsOut[`EFDC_F_VIF]}, 32'h0);
        // virtual-interrupt flags across enter, async exit and resume
        vv = flagsOut[20:19];
        cmd(EFDC_PAGEADD, 32'h0, 1'b0);
        cmd(EFDC_ENTER, 32'h0, 1'b0);
        chk("enter vflags", {30'h0, flagsOut[20:19]}, {30'h0, vv});
        // pop-flags loads the whole image, so carry the virtual flags along
        cmd(EFDC_POP_FLAGS_INSTR, TFI | {11'h0, vv, 19'h0}, 1'b0);
        chk("optout pop_flags_instr tf", {31'h0, flagsOut[`EFDC_F_TF]}, 32'h0);
        cmd(EFDC_AEX, 32'h0, 1'b0);
        chk("aex vflags", {30'h0, flagsOut[20:19]}, {30'h0, vv});
        rdchk(`EFDC_ADDR_SAVFLG, 32'h0018_0000, {11'h0, vv, 19'h0}, "saved vflags");
        cmd(EFDC_RESUME, {11'h0, ~vv, 19'h2}, 1'b0);
        chk("resume vflags", {30'h0, flagsOut[20:19]}, {30'h0, vv});
        cmd(EFDC_EXIT, 32'h0, 1'b0);
        // opt-out entry with trap flag and monitor trap enabled
        ctl(32'hC | CPL3 | IOPL3);
        cmd(EFDC_POP_FLAGS_INSTR, TFI, 1'b0);
        chk("tf set", {31'h0, flagsOut[`EFDC_F_TF]}, 32'h1);
        cmd(EFDC_ENTER, 32'h0, 1'b0);
        chk("masked tf", {31'h0, flagsOut[`EFDC_F_TF]}, 32'h0);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0103, 32'h0000_0101, "optout status");
        cmd(EFDC_RPTKEY, 32'h0, 1'b0);
        chk("masked step", {30'h0, stepPending, mtfPending}, 32'h0);
        cmd(EFDC_EXIT, 32'h0, 1'b0);
        chk("exit tf", {31'h0, flagsOut[`EFDC_F_TF]}, 32'h1);
        chk("exit pend", {30'h0, stepPending, mtfPending}, 32'h3);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0100, 32'h0, "unmasked");
        cmd(EFDC_BOUNDARY, 32'h0, 1'b0);
        cmd(EFDC_ENTER, 32'h0, 1'b0);
        cmd(EFDC_AEX, 32'h0, 1'b0);
        chk("aex mtf", {31'h0, mtfPending}, 32'h1);
        chk("aex tf", {31'h0, flagsOut[`EFDC_F_TF]}, 32'h1);
        cmd(EFDC_OTHERVMX, 32'h0, 1'b0);
        chk("mtf dropped", {31'h0, mtfPending}, 32'h0);
        cmd(EFDC_BOUNDARY, 32'h0, 1'b0);
        // privileged instruction stepping, clean and faulting
        cmd(EFDC_PRIVINS, 32'h0, 1'b0);
        chk("priv pend", {30'h0, stepPending, mtfPending}, 32'h3);
        cmd(EFDC_BOUNDARY, 32'h0, 1'b0);
        cmd(EFDC_PRIVINS, 32'h0, 1'b1);
        chk("fault pend", {30'h0, stepPending, mtfPending}, 32'h1);
        cmd(EFDC_OTHERVMX, 32'h0, 1'b0);
        chk("fault mtf drop", {31'h0, mtfPending}, 32'h0);
        // debug access and opt-in
        ctl(32'hC | CPL3 | IOPL3);
        cmd(EFDC_DBGRD, 32'h0, 1'b0);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0020, 32'h0000_0020, "prod refused");
        ctl(32'h2D | CPL3 | IOPL3);
        cmd(EFDC_DBGWR, 32'h0, 1'b0);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0020, 32'h0, "debug allowed");
        cmd(EFDC_ENTER, 32'h0, 1'b0);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0003, 32'h0000_0003, "optin status");
        cmd(EFDC_RPTKEY, 32'h0, 1'b0);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0002, 32'h0000_0002, "optin held");
        chk("optin step", {31'h0, stepPending}, 32'h1);
        cmd(EFDC_BOUNDARY, 32'h0, 1'b0);
        cmd(EFDC_AEX, 32'h0, 1'b0);
        chk("optin aex tf", {31'h0, flagsOut[`EFDC_F_TF]}, 32'h1);
        rdchk(`EFDC_ADDR_SAVFLG, 32'h0000_0100, 32'h0, "saved tf");
        @(posedge mclk);
        cmdIret <= 1'b1;
        @(posedge mclk);
        cmdIret <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("interrupt_return_instr step", {31'h0, stepPending}, 32'h1);
        cmd(EFDC_BOUNDARY, 32'h0, 1'b0);
        cmd(EFDC_PAGEADD, 32'h0, 1'b0);
        cmd(EFDC_ENTER, 32'h0, 1'b0);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0002, 32'h0, "pageadd optout");
        cmd(EFDC_EXIT, 32'h0, 1'b0);
        // protection key register save, clear and restore
        ctl(32'h12 | CPL3 | IOPL3);
        wr(`EFDC_ADDR_KEYREG, 32'hA5A5_1234, r);
        rdchk(`EFDC_ADDR_KEYREG, 32'hFFFF_FFFF, 32'hA5A5_1234, "key rw");
        cmd(EFDC_ENTER, 32'h0, 1'b0);
        cmd(EFDC_AEX, 32'h0, 1'b0);
        rdchk(`EFDC_ADDR_SAVKEY, 32'hFFFF_FFFF, 32'hA5A5_1234, "key saved");
        rdchk(`EFDC_ADDR_KEYREG, 32'hFFFF_FFFF, 32'h0, "key cleared");
        cmd(EFDC_RESUME, TFI, 1'b0);
        rdchk(`EFDC_ADDR_KEYREG, 32'hFFFF_FFFF, 32'hA5A5_1234, "key restored");
        cmd(EFDC_EXIT, 32'h0, 1'b0);
        // domain checks: enabled, implicit, disabled
        wr(`EFDC_ADDR_ACCESS, 32'h0000_0003, r);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0080, 32'h0000_0080, "domain deny");
        wr(`EFDC_ADDR_ACCESS, 32'h0000_000B, r);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0080, 32'h0, "implicit pass");
        ctl(CPL3 | IOPL3);
        rdchk(`EFDC_ADDR_KEYREG, 32'hFFFF_FFFF, 32'h0, "key off");
        wr(`EFDC_ADDR_ACCESS, 32'h0000_0003, r);
        rdchk(`EFDC_ADDR_STATUS, 32'h0000_0080, 32'h0, "keys off pass");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
